// ---- hw/hdlc_tx_pkg.sv ----
package hdlc_tx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_SBP   = 8'h04;
  localparam logic [7:0] ADDR_DATA  = 8'h08;
  localparam logic [7:0] ADDR_FSTAT = 8'h0c;
  localparam logic [7:0] ADDR_THR   = 8'h10;
  localparam logic [7:0] ADDR_LEN   = 8'h14;
  localparam logic [7:0] ADDR_RESID = 8'h18;
  localparam logic [7:0] ADDR_FIE   = 8'h1c;
  localparam logic [7:0] ADDR_ISRC  = 8'h20;
  localparam logic [7:0] ADDR_CNT   = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CMD_ABORT    = 0;
  localparam int CMD_TXEN     = 1;
  localparam int CMD_FLAGIDLE = 3;
  localparam int CMD_SWRST    = 6;
  localparam int SBP_INV      = 5;
  localparam int SBP_LLOOP    = 6;
  localparam int SBP_RLOOP    = 7;
  localparam int FST_THR      = 2;
  localparam int FST_BA       = 3;
  localparam int FST_UNDER    = 4;
  localparam int ISRC_FIFO    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and line characters.
  localparam logic [7:0] CMD_RST     = 8'h00;
  localparam logic [7:0] SBP_RST     = 8'h00;
  localparam logic [3:0] THR_RST     = 4'h0;
  localparam logic [7:0] FLAG_CHAR   = 8'h7e;
  localparam logic [7:0] MARK_CHAR   = 8'hff;
  localparam logic [7:0] ABORT_CHAR  = 8'h3f;
  localparam logic [3:0] ABORT_BITS  = 4'h7;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam int         FIFO_DEPTH  = 16;
  localparam int         FIFO_AW     = 4;
  localparam int         FIFO_W      = 9;
  localparam int         LEN_W       = 16;
  localparam int         CLK_PER_BIT_MIN = 5;

  typedef enum logic [5:0] {
    TX_IDLE  = 6'b000001,
    TX_OPEN  = 6'b000010,
    TX_DATA  = 6'b000100,
    TX_CLOSE = 6'b001000,
    TX_ABORT = 6'b010000,
    TX_UNDER = 6'b100000
  } tx_state_t;

endpackage

// ---- hw/tx_fifo_mem.sv ----
`timescale 1ns/100ps
module tx_fifo_mem #(
  parameter int W  = 9,
  parameter int AW = 4
) (
  // Clock and reset.
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [W-1:0]              rd;
  } mem_st_t;

  mem_st_t st;
  mem_st_t nx;

  // A write to the word being read is passed straight through, so a byte
  // pushed into an empty buffer is poppable one cycle later.
  always_comb begin
    nx = st;
    if (we) begin
      nx.mem[waddr] = wdata;
    end
    nx.rd = (we && waddr == raddr) ? wdata : st.mem[raddr];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign rdata = st.rd;

endmodule

// ---- hw/hdlc_tx.sv ----
`timescale 1ns/100ps
// Function
// - Every abort request sends one whole abort character.
// - Abort honoured even while out of frame.
// - Local loop: transmitter feeds receiver, input cut.
// - Local loop: transmit clock times both directions.
// - Remote loop: serial input echoed, transmitter cut.
// - Echo bit sampled rising, driven next falling.
// - Remote loop: transmitter runs, output never reaches pin.
// - Disable in frame: finish closing flag, release.
// - Underrun sets status bit and interrupt source.
// - Underrun: one abort, idle, clear FIFO, counters.
// - Last byte sends only programmed residual bits.
// - Bit rate up to clock divided by five.
// - Sixteen nine-bit entries, tag marks last byte.
// - FIFO emptied on reset, abort, underrun.
// - Threshold status and falling-to-threshold interrupt.
// - Buffer available: not full, no tagged byte.
// - Packet length cleared on reset, abort, underrun.
// - Out of frame, length write loads counter.
// - Tagged pop reloads counter, deferred during write.
// - Counter decrements per push, zero byte tagged.
// - Request when count, no tag, level at or below threshold.
// - Request held until count zero or full.
// - Request dropped during acknowledge or data write.
// - Enable bit; disabled output pulled low only to finish a frame or to echo in remote loop.
module hdlc_tx #(
  parameter int LEN_W = hdlc_tx_pkg::LEN_W
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // DMA handshake.
  input  wire logic        dma_acknowledge_n,
  output logic             tx_dma_request,
  // Serial bus port pins; the output is open drain.
  input  wire logic        frame_sync_or_tx_clock,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  // Receiver input after the loop selector.
  output logic             rx_serial_data,
  output logic             rx_bit_clock
);

  localparam int DEPTH = hdlc_tx_pkg::FIFO_DEPTH;
  localparam int AW    = hdlc_tx_pkg::FIFO_AW;

  typedef struct packed {
    logic                  ck_s1, ck_s2, ck_d;
    logic                  din_s1, din_s2;
    logic                  ack_s1, ack_s2;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [7:0]            cmd, serial_bus_port, fie;
    logic [3:0]            thr;
    logic [2:0]            resid;
    logic [LEN_W-1:0]      len, cnt;
    logic                  reload_pend;
    logic                  under_f, isrc;
    logic [AW-1:0]         wptr, rptr;
    logic [AW:0]           level;
    logic                  tag_in;
    logic                  abort_pend;
    hdlc_tx_pkg::tx_state_t state;
    logic [7:0]            sh;
    logic [3:0]            nbits;
    logic                  last_byte;
    logic                  txbit, echo, echo_smp, drv;
    logic                  oe, rxd, rxc, drq;
    logic [31:0]           hrdata;
    logic                  rdy;
  } st_t;

  st_t st;
  st_t nx;

  logic              mem_we;
  logic [AW-1:0]     mem_waddr;
  logic [8:0]        mem_wdata;
  logic [8:0]        mem_rdata;

  //////////////////////////////////////////////////////////////////////////
  // sixteen tagged entries
  tx_fifo_mem #(
    .W  (hdlc_tx_pkg::FIFO_W),
    .AW (AW)
  ) i_tx_fifo_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr   (st.rptr),
    .rdata   (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  logic             fall, rise, ap, wr_data, wr_len, in_frame, clr, push, pop, full;
  logic             abort_req, drive_ok, pin_bit, ack_now;
  logic [7:0]       ch;
  logic [3:0]       chlen;
  logic [AW:0]      lvl;

  always_comb begin
    nx        = st;
    mem_we    = 1'b0;
    mem_waddr = st.wptr;
    mem_wdata = '0;
    ch        = hdlc_tx_pkg::MARK_CHAR;
    chlen     = hdlc_tx_pkg::BYTE_BITS;
    clr       = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    full      = (st.level == (AW+1)'(DEPTH));
    in_frame  = (st.state == hdlc_tx_pkg::TX_OPEN) || (st.state == hdlc_tx_pkg::TX_DATA) ||
                (st.state == hdlc_tx_pkg::TX_CLOSE);
    // Pins pass two flip-flops; the second stage is looked at, and the clock also a third for edges.
    nx.ck_s1  = frame_sync_or_tx_clock;
    nx.ck_s2  = st.ck_s1;
    nx.ck_d   = st.ck_s2;
    nx.din_s1 = serial_in_pin;
    nx.din_s2 = st.din_s1;
    nx.ack_s1 = dma_acknowledge_n;
    nx.ack_s2 = st.ack_s1;
    // edge detect at clk/5
    // Each clock level must last two system clocks to be seen, so a link
    // clock at or below one fifth of hclk is never missed.
    fall = st.ck_d & ~st.ck_s2;
    rise = ~st.ck_d & st.ck_s2;

    // Bus slave: zero wait states, always OKAY, unmapped reads as zero.
    ap          = hsel & hready & htrans[1];
    nx.wr_pend  = ap & hwrite;
    nx.wr_addr  = haddr[7:0];
    nx.rdy      = 1'b1;
    wr_data     = st.wr_pend && (st.wr_addr == hdlc_tx_pkg::ADDR_DATA);
    wr_len      = st.wr_pend && (st.wr_addr == hdlc_tx_pkg::ADDR_LEN);
    if (ap && !hwrite) begin
      case (haddr[7:0])
        hdlc_tx_pkg::ADDR_CMD:   nx.hrdata = {24'h0, st.cmd};
        hdlc_tx_pkg::ADDR_SBP:   nx.hrdata = {24'h0, st.serial_bus_port};
        hdlc_tx_pkg::ADDR_FSTAT: nx.hrdata = {27'h0, st.under_f,
                                             ~full & ~st.tag_in,
                                             st.level <= {1'b0, st.thr}, 2'h0};
        hdlc_tx_pkg::ADDR_THR:   nx.hrdata = {28'h0, st.thr};
        hdlc_tx_pkg::ADDR_LEN:   nx.hrdata = 32'(st.len);
        hdlc_tx_pkg::ADDR_RESID: nx.hrdata = {29'h0, st.resid};
        hdlc_tx_pkg::ADDR_FIE:   nx.hrdata = {24'h0, st.fie};
        hdlc_tx_pkg::ADDR_ISRC:  nx.hrdata = {31'h0, st.isrc};
        hdlc_tx_pkg::ADDR_CNT:   nx.hrdata = 32'(st.cnt);
        default:                 nx.hrdata = 32'h0;
      endcase
    end
    if (st.wr_pend) begin
      case (st.wr_addr)
        hdlc_tx_pkg::ADDR_CMD: begin
          nx.cmd = hwdata[7:0];
          if (hwdata[hdlc_tx_pkg::CMD_ABORT]) begin
            nx.abort_pend = 1'b1;
          end
        end
        hdlc_tx_pkg::ADDR_SBP:   nx.serial_bus_port = hwdata[7:0];
        hdlc_tx_pkg::ADDR_THR:   nx.thr = hwdata[3:0];
        hdlc_tx_pkg::ADDR_RESID: nx.resid = hwdata[2:0];
        hdlc_tx_pkg::ADDR_FIE:   nx.fie = hwdata[7:0];
        hdlc_tx_pkg::ADDR_FSTAT: begin
          if (hwdata[hdlc_tx_pkg::FST_UNDER]) begin
            nx.under_f = 1'b0;
          end
        end
        hdlc_tx_pkg::ADDR_ISRC: begin
          if (hwdata[hdlc_tx_pkg::ISRC_FIFO]) begin
            nx.isrc = 1'b0;
          end
        end
        hdlc_tx_pkg::ADDR_LEN: begin
          nx.len = hwdata[LEN_W-1:0];
          if (!in_frame) begin
            nx.cnt = hwdata[LEN_W-1:0];
          end
        end
        default: ;
      endcase
    end
    if (wr_data && !full) begin
      push      = 1'b1;
      mem_we    = 1'b1;
      mem_wdata = {st.cnt == LEN_W'(1), hwdata[7:0]};
      if (st.cnt != '0) begin
        nx.cnt = st.cnt - LEN_W'(1);
      end
      if (st.cnt == LEN_W'(1)) begin
        nx.tag_in = 1'b1;
      end
    end
    if (st.reload_pend && !wr_len) begin
      nx.cnt         = st.len;
      nx.reload_pend = 1'b0;
    end

    // Transmit engine, one bit per falling edge of the link clock.
    abort_req = st.abort_pend | st.cmd[hdlc_tx_pkg::CMD_ABORT];
    if (rise) begin
      nx.echo_smp = st.din_s2;
    end
    // echo leaves on falling edge
    // A bit caught on a rising edge waits half a link period for its slot.
    if (fall) begin
      nx.echo = st.echo_smp;
    end
    if (fall) begin
      // an abort char started by a request is not cut
      if (abort_req && (st.nbits == 4'h0 || st.state != hdlc_tx_pkg::TX_ABORT)) begin
        nx.state      = hdlc_tx_pkg::TX_ABORT;
        nx.abort_pend = 1'b0;
        ch            = hdlc_tx_pkg::ABORT_CHAR;
        chlen         = hdlc_tx_pkg::ABORT_BITS;
        clr           = 1'b1;
      end else if (st.nbits == 4'h0) begin
        case (st.state)
          hdlc_tx_pkg::TX_OPEN, hdlc_tx_pkg::TX_DATA: begin
            if (st.last_byte) begin
              nx.state     = hdlc_tx_pkg::TX_CLOSE;
              nx.last_byte = 1'b0;
              ch           = hdlc_tx_pkg::FLAG_CHAR;
            end else if (st.level == '0) begin
              nx.under_f = 1'b1;
              if (st.fie[hdlc_tx_pkg::FST_UNDER]) begin
                nx.isrc = 1'b1;
              end
              nx.state = hdlc_tx_pkg::TX_UNDER;
              ch       = hdlc_tx_pkg::ABORT_CHAR;
              chlen    = hdlc_tx_pkg::ABORT_BITS;
              clr      = 1'b1;
            end else begin
              pop          = 1'b1;
              nx.state     = hdlc_tx_pkg::TX_DATA;
              nx.last_byte = mem_rdata[8];
              ch           = mem_rdata[7:0];
              if (mem_rdata[8] && st.resid != 3'h0) begin
                chlen = {1'b0, st.resid};
              end
            end
          end
          default: begin
            if (st.level != '0) begin
              nx.state = hdlc_tx_pkg::TX_OPEN;
              ch       = hdlc_tx_pkg::FLAG_CHAR;
            end else begin
              nx.state = hdlc_tx_pkg::TX_IDLE;
              ch = st.cmd[hdlc_tx_pkg::CMD_FLAGIDLE] ? hdlc_tx_pkg::FLAG_CHAR :
                                                        hdlc_tx_pkg::MARK_CHAR;
            end
          end
        endcase
      end else begin
        ch    = st.sh;
        chlen = st.nbits;
      end
      nx.txbit = ch[0];
      nx.sh    = {1'b0, ch[7:1]};
      nx.nbits = chlen - 4'h1;
    end

    // reload on tagged pop, defer on write
    if (pop) begin
      nx.rptr = st.rptr + AW'(1);
      if (mem_rdata[8]) begin
        nx.tag_in = 1'b0;
        if (wr_len) begin
          nx.reload_pend = 1'b1;
        end else begin
          nx.cnt = st.len;
        end
      end
    end
    if (push) begin
      nx.wptr = st.wptr + AW'(1);
    end
    lvl = st.level + (AW+1)'(push) - (AW+1)'(pop);
    nx.level = lvl;
    // event when level falls to threshold
    if (pop && !push && lvl == {1'b0, st.thr} && st.fie[hdlc_tx_pkg::FST_THR]) begin
      nx.isrc = 1'b1;
    end
    if (st.cmd[hdlc_tx_pkg::CMD_SWRST]) begin
      clr      = 1'b1;
      nx.cmd   = hdlc_tx_pkg::CMD_RST;
      nx.state = hdlc_tx_pkg::TX_IDLE;
      nx.nbits = 4'h0;
      nx.last_byte  = 1'b0;
      nx.abort_pend = 1'b0;
    end
    if (clr) begin
      nx.wptr        = '0;
      nx.rptr        = '0;
      nx.level       = '0;
      nx.tag_in      = 1'b0;
      nx.len         = '0;
      nx.cnt         = '0;
      nx.reload_pend = 1'b0;
      nx.last_byte   = 1'b0;
    end

    // hold until zero count or full
    ack_now = ~st.ack_s2 | wr_data;
    nx.drq  = ~ack_now && nx.cnt != '0 && !nx.tag_in &&
              ((nx.level <= {1'b0, st.thr}) || (st.drq && nx.level != (AW+1)'(DEPTH)));

    // pin held until the frame ends
    // A frame keeps the pin driven only if it was enabled while the frame ran,
    // so a frame that starts while disabled pulls the line low only after the enable bit is set.
    drive_ok = st.cmd[hdlc_tx_pkg::CMD_TXEN] | (st.drv & in_frame);
    nx.drv   = drive_ok;
    // transmitter output blocked in remote loop
    pin_bit  = st.serial_bus_port[hdlc_tx_pkg::SBP_RLOOP] ? st.echo :
               (st.txbit ^ st.serial_bus_port[hdlc_tx_pkg::SBP_INV]);
    nx.oe    = st.serial_bus_port[hdlc_tx_pkg::SBP_RLOOP] ? ~pin_bit :
               (drive_ok & ~st.serial_bus_port[hdlc_tx_pkg::SBP_LLOOP] & ~pin_bit);
    nx.rxd   = st.serial_bus_port[hdlc_tx_pkg::SBP_LLOOP] ?
               (st.txbit ^ st.serial_bus_port[hdlc_tx_pkg::SBP_INV]) : st.din_s2;
    nx.rxc   = st.ck_s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= '0;
      st.cmd   <= hdlc_tx_pkg::CMD_RST;
      st.serial_bus_port   <= hdlc_tx_pkg::SBP_RST;
      st.thr   <= hdlc_tx_pkg::THR_RST;
      st.state <= hdlc_tx_pkg::TX_IDLE;
      st.txbit <= 1'b1;
      st.rxd   <= 1'b1;
      st.rdy   <= 1'b1;
      st.ack_s1 <= 1'b1;
      st.ack_s2 <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign hrdata            = st.hrdata;
  assign hreadyout         = st.rdy;
  assign hresp             = 1'b0;
  assign tx_dma_request    = st.drq;
  assign serial_out_pin_o  = 1'b0;
  assign serial_out_pin_oe = st.oe;
  assign rx_serial_data    = st.rxd;
  assign rx_bit_clock      = st.rxc;

  //////////////////////////////////////////////////////////////////////////
  AST_ABORT_WHOLE_CHAR: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st.state == hdlc_tx_pkg::TX_ABORT) |-> st.nbits == 4'h6 && st.txbit)
    else $error("abort character not started in full");

  AST_ABORT_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall && abort_req && st.state == hdlc_tx_pkg::TX_IDLE && !st.cmd[hdlc_tx_pkg::CMD_SWRST])
    |=> st.state == hdlc_tx_pkg::TX_ABORT)
    else $error("abort request ignored out of frame");

  AST_LLOOP_CUT: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.serial_bus_port[hdlc_tx_pkg::SBP_LLOOP] && !st.serial_bus_port[hdlc_tx_pkg::SBP_RLOOP]) |=>
    !serial_out_pin_oe && rx_serial_data == ($past(st.txbit) ^ $past(st.serial_bus_port[5])))
    else $error("local loop not isolating the pin");

  AST_RLOOP_ECHO: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.serial_bus_port[hdlc_tx_pkg::SBP_RLOOP] && fall) |=> ##1 serial_out_pin_oe == !$past(st.echo_smp, 2))
    else $error("remote loop echo wrong");

  AST_UNDERRUN: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall && st.state == hdlc_tx_pkg::TX_DATA && st.nbits == 4'h0 && st.level == '0 &&
     !st.last_byte && !abort_req && !st.cmd[hdlc_tx_pkg::CMD_SWRST])
    |=> st.under_f && st.state == hdlc_tx_pkg::TX_UNDER)
    else $error("underrun not flagged");

  AST_CLEAR_ON_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(st.state == hdlc_tx_pkg::TX_ABORT) || $rose(st.state == hdlc_tx_pkg::TX_UNDER))
    |-> st.level == '0 && st.cnt == '0 && st.len == '0)
    else $error("FIFO or counters not cleared by abort");

  AST_FULL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_data && full && !pop && !clr) |=> st.level == (AW+1)'(DEPTH) && $stable(st.cnt))
    else $error("write to full FIFO was taken");

  AST_DRQ_ACK: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st.ack_s2 || wr_data) |=> !tx_dma_request)
    else $error("DMA request held through acknowledge");

  AST_TAG_LAST: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_we && st.cnt == LEN_W'(1)) |=> st.cnt == '0 && st.tag_in)
    else $error("last byte not tagged");

  AST_RELEASED: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st.cmd[hdlc_tx_pkg::CMD_TXEN] && !in_frame && !st.serial_bus_port[hdlc_tx_pkg::SBP_RLOOP])
    |=> !serial_out_pin_oe)
    else $error("disabled transmitter drives the pin");

endmodule

// ---- tb/link_port_model.sv ----
`timescale 1ns/100ps
module link_port_model (
  // Bench control.
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic        echo_val,
  // Link pins.
  input  wire logic        line_oe,
  output logic             link_clk,
  output logic             serial_in,
  // Observed line.
  output logic [31:0]      cap,
  output logic [7:0]       zeros
);
  logic [5:0] n;
  logic       line;
  logic       echo_q = 1'b1;

  assign serial_in = echo_q;

  // The open-drain line has a pull-up, so a released driver reads high.
  assign line = ~line_oe;

  // The clock stands still while the bench holds the link quiet.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #100 link_clk = run ? ~link_clk : 1'b0;
  end

  always @(negedge link_clk) begin
    if (run) begin
      echo_q <= echo_val;
    end
  end

  // The line is read just before the device moves it again; capture starts at the first zero.
  always @(negedge link_clk or posedge clear) begin
    if (clear) begin
      n <= 6'h00;
      cap <= 32'h0;
      zeros <= 8'h00;
    end else begin
      if (!line) zeros <= zeros + 8'h01;
      if (n < 6'h20 && (n != 6'h00 || !line)) begin
        cap[n[4:0]] <= line;
        n <= n + 6'h01;
      end
    end
  end
endmodule

// ---- tb/test_hdlc_tx.sv ----
`timescale 1ns/100ps
module test_hdlc_tx;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        ack_n, drq, lclk, sin, oe, rxd, run, clr, echo, so, rxc;
  logic [31:0] haddr, hwdata, hrdata, cap;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  zeros;
  int          err_total, compares;

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  hdlc_tx i_hdlc_tx (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dma_acknowledge_n(ack_n),
    .tx_dma_request(drq), .frame_sync_or_tx_clock(lclk), .serial_in_pin(sin),
    .serial_out_pin_o(so), .serial_out_pin_oe(oe), .rx_serial_data(rxd), .rx_bit_clock(rxc));

  link_port_model i_link_port_model (.run(run), .clear(clr), .echo_val(echo),
    .line_oe(oe), .link_clk(lclk), .serial_in(sin), .cap(cap), .zeros(zeros));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask

  task automatic bits(input int n);
    repeat (n * 8) @(posedge hclk);
  endtask

  task automatic clear_cap();
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_bit(drq, 1'b0); // request idle
    chk_bit(oe, 1'b0); // line released
    chk_bit(hresp, 1'b0);
    chk_bit(so, 1'b0); // open drain drives low only
    rchk(hdlc_tx_pkg::ADDR_FSTAT, 32'h0c); // status at reset
    rchk(hdlc_tx_pkg::ADDR_LEN, 32'h0); // length cleared
    rchk(8'h3c, 32'h0);
  endtask

  // The link stands still, so nothing leaves the buffer while it is filled.
  task automatic t_full();
    wr(hdlc_tx_pkg::ADDR_THR, 32'h4);
    wr(hdlc_tx_pkg::ADDR_LEN, 32'h14);
    for (int i = 0; i < 17; i++) wr(hdlc_tx_pkg::ADDR_DATA, i);
    rchk(hdlc_tx_pkg::ADDR_CNT, 32'h4); // extra write ignored
    rchk(hdlc_tx_pkg::ADDR_FSTAT, 32'h0); // sixteen entries
    chk_bit(drq, 1'b0); // full drops request
    wr(hdlc_tx_pkg::ADDR_CMD, 32'h40);
    rchk(hdlc_tx_pkg::ADDR_FSTAT, 32'h0c); // buffer emptied
    rchk(hdlc_tx_pkg::ADDR_CNT, 32'h0); // counter cleared
  endtask

  task automatic t_frame();
    run <= 1'b1;
    wr(hdlc_tx_pkg::ADDR_CMD, 32'h2);
    clear_cap();
    wr(hdlc_tx_pkg::ADDR_LEN, 32'h2);
    repeat (4) @(posedge hclk);
    chk_bit(drq, 1'b1); // request rises
    wr(hdlc_tx_pkg::ADDR_DATA, 32'ha5);
    wr(hdlc_tx_pkg::ADDR_DATA, 32'h3c);
    rchk(hdlc_tx_pkg::ADDR_CNT, 32'h0); // count reaches zero
    rchk(hdlc_tx_pkg::ADDR_FSTAT, 32'h04); // tagged byte held
    chk_bit(drq, 1'b0); // request dropped
    bits(50);
    chk(cap, {hdlc_tx_pkg::FLAG_CHAR, 8'h3c, 8'ha5, hdlc_tx_pkg::FLAG_CHAR}); // frame
    chk_bit(drq, 1'b1); // counter reloaded
    ack_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk_bit(drq, 1'b0); // acknowledge drops request
    ack_n <= 1'b1;
  endtask

  task automatic t_abort();
    clear_cap();
    wr(hdlc_tx_pkg::ADDR_CMD, 32'h3);
    wr(hdlc_tx_pkg::ADDR_CMD, 32'h2);
    bits(30);
    chk({24'h0, zeros}, 32'h1); // one abort sent
    rchk(hdlc_tx_pkg::ADDR_LEN, 32'h0); // length cleared
    chk_bit(drq, 1'b0); // request dropped
  endtask

  task automatic t_under();
    wr(hdlc_tx_pkg::ADDR_FIE, 32'h10);
    wr(hdlc_tx_pkg::ADDR_LEN, 32'h3);
    wr(hdlc_tx_pkg::ADDR_DATA, 32'h55);
    bits(40);
    rchk(hdlc_tx_pkg::ADDR_FSTAT, 32'h1c); // underrun flag
    rchk(hdlc_tx_pkg::ADDR_ISRC, 32'h1); // source bit
    rchk(hdlc_tx_pkg::ADDR_LEN, 32'h0); // length cleared
    rchk(hdlc_tx_pkg::ADDR_CNT, 32'h0); // counter cleared
  endtask

  // Three residual bits of the last byte sit between the two flags.
  task automatic t_resid();
    wr(hdlc_tx_pkg::ADDR_RESID, 32'h3);
    clear_cap();
    wr(hdlc_tx_pkg::ADDR_LEN, 32'h1);
    wr(hdlc_tx_pkg::ADDR_DATA, 32'h5);
    bits(48);
    chk(cap, {13'h1fff, hdlc_tx_pkg::FLAG_CHAR, 3'h5, hdlc_tx_pkg::FLAG_CHAR});
    wr(hdlc_tx_pkg::ADDR_RESID, 32'h0);
  endtask

  task automatic t_loops();
    echo <= 1'b0;
    wr(hdlc_tx_pkg::ADDR_SBP, 32'h40);
    bits(2);
    chk_bit(rxd, 1'b1); // receiver sees transmitter
    chk_bit(oe, 1'b0); // pin released
    @(posedge lclk);
    repeat (4) @(posedge hclk);
    chk_bit(rxc, 1'b1); // link clock to receiver
    @(negedge lclk);
    repeat (4) @(posedge hclk);
    chk_bit(rxc, 1'b0); // link clock to receiver
    wr(hdlc_tx_pkg::ADDR_SBP, 32'h80);
    bits(3);
    chk_bit(oe, 1'b1); // input echoed
    echo <= 1'b1;
    bits(3);
    chk_bit(oe, 1'b0); // echo follows
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Compares: %0d, mismatches: %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The tests need about 200 bit periods; the limit leaves wide margin.
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {ack_n, echo, run, clr} = 4'b1100;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_full();
    t_frame();
    t_abort();
    t_under();
    t_resid();
    t_loops();
    end_sim();
  end
endmodule
